// ### design/lut_latch_pkg.sv
`default_nettype none
package lut_latch_pkg;
  localparam int XW = 16;
  localparam int YW = 16;
  localparam int NPTS = 11;
  localparam int PIDX_W = 4;
  localparam int SEL_W = 4;
  localparam int NSRC = 16;
  localparam int AW = 8;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RAMP = 2'h1;
  localparam logic [1:0] RESP_JUMP = 2'h2;
  localparam logic AXIS_DATA = 1'h0;
  localparam logic AXIS_TIME = 1'h1;
  localparam logic [7:0] PCT_FULL = 8'h64;
  // time base
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_TIME = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
  // register map
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_SET_TH = 8'h04;
  localparam logic [AW-1:0] ADDR_RST_TH = 8'h08;
  localparam logic [AW-1:0] ADDR_XRANGE = 8'h0c;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h10;
  localparam logic [AW-1:0] ADDR_YRANGE = 8'h14;
  localparam logic [AW-1:0] ADDR_OUT = 8'h18;
  localparam logic [1:0] REGION_REGS = 2'h0;
  localparam logic [1:0] REGION_X = 2'h1;
  localparam logic [1:0] REGION_Y = 2'h2;
  localparam logic [1:0] REGION_RESP = 2'h3;
  // field positions
  localparam int CTRL_AXIS_BIT = 0;
  localparam int CTRL_REPEAT_BIT = 1;
  localparam int CTRL_SEL_LSB = 4;
  localparam int TH_MIN_LSB = 0;
  localparam int TH_MAX_LSB = 8;
  localparam int XR_MIN_LSB = 0;
  localparam int XR_MAX_LSB = 16;
  // reset values
  localparam logic [7:0] TH_MIN_RST = 8'h19;
  localparam logic [7:0] TH_MAX_RST = 8'h4b;
  localparam logic [XW-1:0] XMIN_RST = 16'h0000;
  localparam logic [XW-1:0] XMAX_RST = 16'hffff;

  typedef struct packed {
    logic [7:0] max;
    logic [7:0] min;
  } thresh_t;

  typedef struct packed {
    logic [XW-1:0] x;
    logic signed [YW-1:0] y;
    logic [1:0] resp;
  } point_t;
endpackage
`default_nettype wire

// ### design/sr_latch_th.sv
`default_nettype none
module sr_latch_th #(
  parameter int SW = 16,
  parameter logic [SW-1:0] FULL = '1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // sources and thresholds
  input wire logic [SW-1:0] set_src,
  input wire logic [SW-1:0] rst_src,
  input wire lut_latch_pkg::thresh_t set_th,
  input wire lut_latch_pkg::thresh_t rst_th,
  // states
  output logic set_on,
  output logic rst_on,
  output logic latch_q
);
  initial begin
    if (SW < 1 || FULL == '0) $error("sr_latch_th: bad parameters");
  end

  ////////////////////////////////////////////////////////////////
  // thresholds with dead band
  function automatic logic level(logic old, logic [SW-1:0] src,
                                 lut_latch_pkg::thresh_t th);
    logic [SW+7:0] scaled;
    logic [SW+7:0] hi;
    logic [SW+7:0] lo;
    scaled = src * lut_latch_pkg::PCT_FULL;
    hi = th.max * FULL;
    lo = th.min * FULL;
    if (scaled >= hi) begin
      return 1'b1;
    end else if (scaled <= lo) begin
      return 1'b0;
    end
    return old;
  endfunction

  logic set_on_reg;
  logic rst_on_reg;
  logic latch_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      set_on_reg <= 1'b0;
      rst_on_reg <= 1'b0;
    end else begin
      set_on_reg <= level(set_on_reg, set_src, set_th);
      rst_on_reg <= level(rst_on_reg, rst_src, rst_th);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      latch_reg <= 1'b0;
    end else if (rst_on_reg) begin
      latch_reg <= 1'b0;
    end else if (set_on_reg) begin
      latch_reg <= 1'b1;
    end
  end

  assign set_on = set_on_reg;
  assign rst_on = rst_on_reg;
  assign latch_q = latch_reg;

  ////////////////////////////////////////////////////////////////
  a_reset_wins: assert property (@(posedge core_clk) disable iff (srst)
    rst_on_reg |=> !latch_reg) else $error("latch not off under reset input");
  a_set_turns_on: assert property (@(posedge core_clk) disable iff (srst)
    set_on_reg && !rst_on_reg |=> latch_reg) else $error("latch not set");
  a_latch_holds: assert property (@(posedge core_clk) disable iff (srst)
    !set_on_reg && !rst_on_reg |=> $stable(latch_reg)) else $error("latch moved");
  a_band_hold: assert property (@(posedge core_clk) disable iff (srst)
    ((SW+8)'(set_src) * lut_latch_pkg::PCT_FULL < (SW+8)'(set_th.max) * FULL) &&
    ((SW+8)'(set_src) * lut_latch_pkg::PCT_FULL > (SW+8)'(set_th.min) * FULL)
    |=> $stable(set_on_reg)) else $error("dead band not held");
endmodule
`default_nettype wire

// ### design/lut_point_mem.sv
`default_nettype none
module lut_point_mem #(
  parameter int DEPTH = lut_latch_pkg::NPTS,
  parameter int IW = lut_latch_pkg::PIDX_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // write port, one enable per field
  input wire logic [2:0] wr_field,
  input wire logic [IW-1:0] wr_idx,
  input wire lut_latch_pkg::point_t wr_pt,
  // two read ports
  input wire logic [IW-1:0] rd_idx_a,
  output lut_latch_pkg::point_t rd_pt_a,
  input wire logic [IW-1:0] rd_idx_b,
  output lut_latch_pkg::point_t rd_pt_b
);
  initial begin
    if (DEPTH < 2 || DEPTH > (1 << IW)) $error("lut_point_mem: bad depth");
  end

  lut_latch_pkg::point_t mem_reg [DEPTH];
  lut_latch_pkg::point_t rd_a_reg;
  lut_latch_pkg::point_t rd_b_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (32'(wr_idx) < DEPTH) begin
      if (wr_field[0]) mem_reg[wr_idx].x <= wr_pt.x;
      if (wr_field[1]) mem_reg[wr_idx].y <= wr_pt.y;
      if (wr_field[2]) mem_reg[wr_idx].resp <= wr_pt.resp;
    end
  end

  function automatic lut_latch_pkg::point_t fetch(logic [IW-1:0] idx);
    lut_latch_pkg::point_t p;
    p = (32'(idx) < DEPTH) ? mem_reg[idx] : '0;
    if (idx == '0) p.resp = lut_latch_pkg::RESP_JUMP;
    return p;
  endfunction

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_a_reg <= '0;
      rd_b_reg <= '0;
    end else begin
      rd_a_reg <= fetch(rd_idx_a);
      rd_b_reg <= fetch(rd_idx_b);
    end
  end

  assign rd_pt_a = rd_a_reg;
  assign rd_pt_b = rd_b_reg;

  a_zero_is_jump: assert property (@(posedge core_clk) disable iff (srst)
    rd_idx_a == '0 |=> rd_a_reg.resp == lut_latch_pkg::RESP_JUMP)
    else $error("point zero not jump");
endmodule
`default_nettype wire

// ### design/lut_latch_top.sv
`default_nettype none
module lut_latch_top #(
  parameter int MS_CYC = lut_latch_pkg::MS_CYCLES,
  parameter logic [15:0] SRC_FULL = 16'hffff
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lut_latch_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sources from other blocks
  input wire logic [lut_latch_pkg::NSRC-1:0][15:0] src_data,
  input wire logic [15:0] latch_set_src,
  input wire logic [15:0] latch_rst_src,
  // results
  output logic latch_out,
  output logic signed [lut_latch_pkg::YW-1:0] lut_out,
  output logic signed [lut_latch_pkg::YW-1:0] lut_out_min,
  output logic signed [lut_latch_pkg::YW-1:0] lut_out_max,
  output logic lut_done
);
  localparam int XW = lut_latch_pkg::XW;
  localparam int YW = lut_latch_pkg::YW;
  localparam int IW = lut_latch_pkg::PIDX_W;
  localparam int MSW = $clog2(MS_CYC + 1);

  initial begin
    if (MS_CYC < 1) $error("lut_latch_top: MS_CYC must be positive");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EVAL, ST_DONE} sweep_t;

  ////////////////////////////////////////////////////////////////
  // apb registers
  logic [7:0] ctrl_reg;
  lut_latch_pkg::thresh_t set_th_reg;
  lut_latch_pkg::thresh_t rst_th_reg;
  logic [XW-1:0] xmin_reg;
  logic [XW-1:0] xmax_reg;
  logic ack_reg;
  logic [31:0] prdata_reg;
  logic [1:0] region;
  logic [IW-1:0] bus_idx;
  logic idx_ok;
  logic reg_ok;
  logic wr_go;
  logic [2:0] wr_field;
  lut_latch_pkg::point_t wr_pt;
  lut_latch_pkg::point_t pt_a;
  lut_latch_pkg::point_t pt_b;
  logic set_on;
  logic rst_on;

  assign region = paddr[7:6];
  assign bus_idx = paddr[5:2];
  assign idx_ok = 32'(bus_idx) < lut_latch_pkg::NPTS && paddr[1:0] == 2'h0;
  assign reg_ok = paddr == lut_latch_pkg::ADDR_CTRL || paddr == lut_latch_pkg::ADDR_SET_TH
    || paddr == lut_latch_pkg::ADDR_RST_TH || paddr == lut_latch_pkg::ADDR_XRANGE
    || paddr == lut_latch_pkg::ADDR_STATUS || paddr == lut_latch_pkg::ADDR_YRANGE
    || paddr == lut_latch_pkg::ADDR_OUT;
  assign pready = ack_reg;
  assign pslverr = ack_reg && (region == lut_latch_pkg::REGION_REGS ? !reg_ok : !idx_ok);
  assign wr_go = psel && penable && ack_reg && pwrite && !pslverr;

  // every access answers on its second access cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= '0;
      set_th_reg <= {lut_latch_pkg::TH_MAX_RST, lut_latch_pkg::TH_MIN_RST};
      rst_th_reg <= {lut_latch_pkg::TH_MAX_RST, lut_latch_pkg::TH_MIN_RST};
      xmin_reg <= lut_latch_pkg::XMIN_RST;
      xmax_reg <= lut_latch_pkg::XMAX_RST;
    end else if (wr_go && region == lut_latch_pkg::REGION_REGS) begin
      case (paddr)
        lut_latch_pkg::ADDR_CTRL: ctrl_reg <= pwdata[7:0];
        lut_latch_pkg::ADDR_SET_TH: set_th_reg <= pwdata[15:0];
        lut_latch_pkg::ADDR_RST_TH: rst_th_reg <= pwdata[15:0];
        lut_latch_pkg::ADDR_XRANGE: begin
          xmin_reg <= pwdata[lut_latch_pkg::XR_MIN_LSB +: XW];
          xmax_reg <= pwdata[lut_latch_pkg::XR_MAX_LSB +: XW];
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    wr_field = 3'h0;
    if (wr_go) begin
      case (region)
        lut_latch_pkg::REGION_X: wr_field = 3'h1;
        lut_latch_pkg::REGION_Y: wr_field = 3'h2;
        lut_latch_pkg::REGION_RESP: wr_field = 3'h4;
        default: wr_field = 3'h0;
      endcase
    end
    wr_pt.x = pwdata[XW-1:0];
    wr_pt.y = pwdata[YW-1:0];
    wr_pt.resp = pwdata[1:0];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_reg <= '0;
    end else if (psel && penable && !ack_reg) begin
      case (paddr)
        lut_latch_pkg::ADDR_CTRL: prdata_reg <= {24'h0, ctrl_reg};
        lut_latch_pkg::ADDR_SET_TH: prdata_reg <= {16'h0, set_th_reg};
        lut_latch_pkg::ADDR_RST_TH: prdata_reg <= {16'h0, rst_th_reg};
        lut_latch_pkg::ADDR_XRANGE: prdata_reg <= {xmax_reg, xmin_reg};
        lut_latch_pkg::ADDR_STATUS: prdata_reg <= {29'h0, rst_on, set_on, latch_out};
        lut_latch_pkg::ADDR_YRANGE: prdata_reg <= {lut_out_max, lut_out_min};
        lut_latch_pkg::ADDR_OUT: prdata_reg <= {{(32-YW){lut_out[YW-1]}}, lut_out};
        default: prdata_reg <= '0;
      endcase
    end
  end

  always_comb begin
    case (region)
      lut_latch_pkg::REGION_X: prdata = idx_ok ? {16'h0, pt_b.x} : '0;
      lut_latch_pkg::REGION_Y: prdata = idx_ok ? {16'h0, pt_b.y} : '0;
      lut_latch_pkg::REGION_RESP: prdata = idx_ok ? {30'h0, pt_b.resp} : '0;
      default: prdata = prdata_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // latch and point store
  sr_latch_th #(.SW(16), .FULL(SRC_FULL)) u_latch (
    .core_clk(core_clk),
    .srst(srst),
    .set_src(latch_set_src),
    .rst_src(latch_rst_src),
    .set_th(set_th_reg),
    .rst_th(rst_th_reg),
    .set_on(set_on),
    .rst_on(rst_on),
    .latch_q(latch_out)
  );

  sweep_t state_reg;
  logic [IW-1:0] idx_reg;

  lut_point_mem #(.DEPTH(lut_latch_pkg::NPTS), .IW(IW)) u_mem (
    .core_clk(core_clk),
    .srst(srst),
    .wr_field(wr_field),
    .wr_idx(bus_idx),
    .wr_pt(wr_pt),
    .rd_idx_a(idx_reg),
    .rd_pt_a(pt_a),
    .rd_idx_b(bus_idx),
    .rd_pt_b(pt_b)
  );

  ////////////////////////////////////////////////////////////////
  // input selection and elapsed time
  logic time_mode;
  logic [15:0] sel_src;
  logic enable;
  logic en_prev_reg;
  logic [MSW-1:0] ms_cnt_reg;
  logic ms_tick;
  logic [XW-1:0] elapsed_reg;
  logic restart_reg;

  assign time_mode = ctrl_reg[lut_latch_pkg::CTRL_AXIS_BIT] == lut_latch_pkg::AXIS_TIME;
  assign sel_src = src_data[ctrl_reg[lut_latch_pkg::CTRL_SEL_LSB +: lut_latch_pkg::SEL_W]];
  assign enable = sel_src != 16'h0000;
  assign ms_tick = ms_cnt_reg == MSW'(MS_CYC - 1);

  always_ff @(posedge core_clk) begin
    if (srst || ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_prev_reg <= 1'b0;
      elapsed_reg <= '0;
    end else begin
      en_prev_reg <= enable;
      if (!enable || !en_prev_reg || restart_reg) begin
        elapsed_reg <= '0;
      end else if (ms_tick && elapsed_reg != '1) begin
        elapsed_reg <= elapsed_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // table sweep
  function automatic logic [XW-1:0] clamp_x(logic [XW-1:0] x, logic [XW-1:0] lo,
                                            logic [XW-1:0] hi);
    if (x < lo) return lo;
    if (x > hi) return hi;
    return x;
  endfunction

  function automatic logic signed [YW-1:0] interp(logic [XW-1:0] x0, logic [XW-1:0] x1,
      logic [XW-1:0] v, logic signed [YW-1:0] y0, logic signed [YW-1:0] y1);
    logic signed [YW:0] dy;
    logic signed [XW:0] dx;
    logic signed [XW:0] span;
    logic signed [YW+XW+1:0] prod;
    logic signed [YW+XW+1:0] q;
    dy = {y1[YW-1], y1} - {y0[YW-1], y0};
    dx = {1'b0, v - x0};
    span = {1'b0, x1 - x0};
    if (x1 == x0) return y1;
    prod = dy * dx;
    q = prod / span;
    return y0 + q[YW-1:0];
  endfunction

  logic [XW-1:0] v_reg;
  logic [XW-1:0] prev_x_reg;
  logic signed [YW-1:0] prev_y_reg;
  logic signed [YW-1:0] res_reg;
  logic signed [YW-1:0] ymin_reg;
  logic signed [YW-1:0] ymax_reg;
  logic found_reg;
  logic signed [YW-1:0] out_reg;
  logic signed [YW-1:0] omin_reg;
  logic signed [YW-1:0] omax_reg;
  logic done_reg;
  logic active;
  logic last;
  logic [XW-1:0] x_eff;

  assign active = idx_reg == '0 || pt_a.resp != lut_latch_pkg::RESP_IGNORE;
  assign last = 32'(idx_reg) == lut_latch_pkg::NPTS - 1;
  // x kept rising and in range
  assign x_eff = clamp_x((idx_reg != '0 && pt_a.x < prev_x_reg) ? prev_x_reg : pt_a.x,
                         xmin_reg, xmax_reg);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      idx_reg <= '0;
      v_reg <= '0;
      prev_x_reg <= '0;
      prev_y_reg <= '0;
      res_reg <= '0;
      ymin_reg <= '0;
      ymax_reg <= '0;
      found_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          idx_reg <= '0;
          found_reg <= 1'b0;
          v_reg <= time_mode ? elapsed_reg : sel_src;
          state_reg <= ST_FETCH;
        end
        ST_FETCH: state_reg <= ST_EVAL;
        ST_EVAL: begin
          if (active) begin
            prev_x_reg <= x_eff;
            prev_y_reg <= pt_a.y;
            ymin_reg <= (idx_reg == '0 || pt_a.y < ymin_reg) ? pt_a.y : ymin_reg;
            ymax_reg <= (idx_reg == '0 || pt_a.y > ymax_reg) ? pt_a.y : ymax_reg;
            if (!found_reg && v_reg <= x_eff) begin
              found_reg <= 1'b1;
              if (idx_reg == '0 || pt_a.resp != lut_latch_pkg::RESP_RAMP) begin
                res_reg <= pt_a.y;
              end else begin
                res_reg <= interp(prev_x_reg, x_eff, v_reg, prev_y_reg, pt_a.y);
              end
            end
          end
          if (!active || last) begin
            state_reg <= ST_DONE;
          end else begin
            idx_reg <= idx_reg + 1'b1;
            state_reg <= ST_FETCH;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_reg <= '0;
      omin_reg <= '0;
      omax_reg <= '0;
      done_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      done_reg <= state_reg == ST_DONE;
      restart_reg <= state_reg == ST_DONE && time_mode && !found_reg
        && ctrl_reg[lut_latch_pkg::CTRL_REPEAT_BIT];
      if (state_reg == ST_DONE) begin
        out_reg <= found_reg ? res_reg : prev_y_reg;
        omin_reg <= ymin_reg;
        omax_reg <= ymax_reg;
      end
    end
  end

  assign lut_out = out_reg;
  assign lut_out_min = omin_reg;
  assign lut_out_max = omax_reg;
  assign lut_done = done_reg;

  ////////////////////////////////////////////////////////////////
  a_ignore_stops: assert property (@(posedge core_clk) disable iff (srst)
    state_reg == ST_EVAL && !active |=> state_reg == ST_DONE)
    else $error("sweep continued past ignore");
  a_x_rising: assert property (@(posedge core_clk) disable iff (srst)
    state_reg == ST_EVAL && idx_reg != '0 && xmin_reg <= xmax_reg && prev_x_reg >= xmin_reg
    |-> x_eff >= prev_x_reg || x_eff == xmax_reg) else $error("x order broken");
  a_repeat_data: assert property (@(posedge core_clk) disable iff (srst)
    !time_mode ##1 !time_mode |-> !restart_reg) else $error("repeat in data mode");
  a_elapsed_start: assert property (@(posedge core_clk) disable iff (srst)
    enable && !en_prev_reg |=> elapsed_reg == '0) else $error("elapsed not cleared");
  a_out_in_range: assert property (@(posedge core_clk) disable iff (srst)
    done_reg && $past(found_reg, 2) |-> out_reg >= omin_reg && out_reg <= omax_reg)
    else $error("output outside y range");
  a_jump_value: assert property (@(posedge core_clk) disable iff (srst)
    state_reg == ST_EVAL && active && !found_reg && v_reg <= x_eff
    && pt_a.resp == lut_latch_pkg::RESP_JUMP |=> res_reg == $past(pt_a.y))
    else $error("jump value wrong");
  a_data_source: assert property (@(posedge core_clk) disable iff (srst)
    state_reg == ST_IDLE && !time_mode |=> v_reg == $past(sel_src))
    else $error("wrong data source");
endmodule
`default_nettype wire

// ### verif/src_blocks_model.sv
`default_nettype none
module src_blocks_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // load from bench
  input wire logic ld,
  input wire logic [4:0] ld_idx,
  input wire logic [15:0] ld_val,
  // sources
  output logic [lut_latch_pkg::NSRC-1:0][15:0] src_data,
  output logic [15:0] latch_set_src,
  output logic [15:0] latch_rst_src
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      src_data <= '0;
      latch_set_src <= 16'h0000;
      latch_rst_src <= 16'h0000;
    end else if (ld && ld_idx == 5'h10) begin
      latch_set_src <= ld_val;
    end else if (ld && ld_idx == 5'h11) begin
      latch_rst_src <= ld_val;
    end else if (ld) begin
      src_data[ld_idx[3:0]] <= ld_val;
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_latch_and_lookup_table.sv
`default_nettype none
module tb_latch_and_lookup_table;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, latch_out, lut_done;
  logic ld = 1'b0;
  logic [4:0] ld_idx = 5'h00;
  logic [15:0] ld_val = 16'h0000, set_src, rst_src;
  logic [lut_latch_pkg::NSRC-1:0][15:0] src_data;
  logic signed [15:0] lut_out, lut_out_min, lut_out_max;
  int miscompares = 0, check_count = 0;
  int px[3], py[3], pr[3];

  always #10 core_clk = ~core_clk;

  src_blocks_model i_src (.core_clk(core_clk), .srst(srst), .ld(ld), .ld_idx(ld_idx),
    .ld_val(ld_val), .src_data(src_data), .latch_set_src(set_src), .latch_rst_src(rst_src));
  lut_latch_top #(.MS_CYC(10)) i_dut (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_data(src_data), .latch_set_src(set_src),
    .latch_rst_src(rst_src), .latch_out(latch_out), .lut_out(lut_out),
    .lut_out_min(lut_out_min), .lut_out_max(lut_out_max), .lut_done(lut_done));

  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      chk("pready", 32'h1, 32'h0);
      close_out();
    end
  endtask

  task automatic put(input int i, input logic [15:0] v);
    @(posedge core_clk);
    ld <= 1'b1;
    ld_idx <= 5'(i);
    ld_val <= v;
    @(posedge core_clk);
    ld <= 1'b0;
  endtask

  task automatic wait_done(input int n);
    int k;
    k = 0;
    for (int c = 0; c < 200 && k < n; c++) begin
      @(posedge core_clk);
      if (lut_done === 1'b1) k++;
    end
    if (k < n) begin
      chk("lut_done", 32'h1, 32'h0);
      close_out();
    end
  endtask

  // expected table output for the three active points
  function automatic int lut_exp(input int v);
    if (v <= px[0]) return py[0];
    for (int i = 1; i < 3; i++) begin
      if (v <= px[i] && pr[i] == 2) return py[i];
      if (v <= px[i]) return py[i-1] + (py[i] - py[i-1]) * (v - px[i-1]) / (px[i] - px[i-1]);
    end
    return py[2];
  endfunction

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] st[9];
    logic [15:0] rs[9];
    logic [2:0] ex[9];
    logic [7:0] ra[6];
    logic [31:0] re[6];
    int cv[7];
    int v;
    int sel;
    int seen;
    st = '{16'hffff, 0, 16'hffff, 0, 16'hffff, 0, 16'h4000, 0, 16'h6666};
    rs = '{0, 0, 16'hffff, 0, 0, 0, 16'hffff, 0, 0};
    ex = '{3'h3, 3'h1, 3'h6, 3'h0, 3'h3, 3'h3, 3'h6, 3'h0, 3'h3};
    ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'hc0, 8'hc4};
    re = '{32'h0, 32'h4b19, 32'h4b19, 32'hffff0000, 32'h2, 32'h0};
    cv = '{0, 20, 21, 60, 100, 150, 200};
    px = '{20, 100, 200};
    py = '{300, 1000, -500};
    pr = '{2, 1, 2};
    void'($urandom(67));
    st[5] = 16'h4000 + 16'($urandom % 32768);
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    chk("latch reset", 32'h0, 32'(latch_out));
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset reg", re[i], rd);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b0, 8'h6c, 32'h0);
    chk("index 11 err", 32'h1, 32'(err));
    apb(1'b1, 8'hc0, 32'h1);
    apb(1'b0, 8'hc0, 32'h0);
    chk("resp0", 32'h2, rd);
    $display("registers done");
    for (int i = 0; i < 9; i++) begin
      if (i == 7) apb(1'b1, 8'h04, 32'h280a);
      put(16, st[i]);
      put(17, rs[i]);
      repeat (3) @(posedge core_clk);
      chk("latch_out", 32'(ex[i][0]), 32'(latch_out));
      apb(1'b0, 8'h10, 32'h0);
      chk("status", 32'(ex[i]), rd);
    end
    $display("latch done");
    apb(1'b1, 8'hc4, 32'h1);
    apb(1'b1, 8'hc8, 32'h2);
    apb(1'b1, 8'h48, 32'd200);
    apb(1'b1, 8'h44, 32'd100);
    apb(1'b1, 8'h40, 32'd20);
    apb(1'b1, 8'h80, 32'd300);
    apb(1'b1, 8'h84, 32'd1000);
    apb(1'b1, 8'h88, 32'hfe0c);
    for (int i = 0; i < 16; i++) begin
      sel = $urandom % 16;
      v = (i < 7) ? cv[i] : $urandom % 260;
      apb(1'b1, 8'h00, 32'(sel << 4) | 32'(($urandom % 2) << 1));
      put(sel, 16'(v));
      put((sel + 1) % 16, 16'($urandom));
      wait_done(2);
      chk("lut_out", 32'(lut_exp(v)), 32'(lut_out));
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("out reg", 32'(lut_exp(v)), rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("y range", 32'h03e8fe0c, rd);
    chk("y pins", 32'h03e8fe0c, {lut_out_max, lut_out_min});
    apb(1'b1, 8'h0c, 32'hffff0032);
    apb(1'b1, 8'h00, 32'h0);
    put(0, 16'd60);
    wait_done(2);
    chk("x clamp", 32'd440, 32'(lut_out));
    $display("data mode done");
    apb(1'b1, 8'h0c, 32'hffff0000);
    apb(1'b1, 8'hc8, 32'h0);
    apb(1'b1, 8'h40, 32'h0);
    apb(1'b1, 8'h44, 32'd5);
    apb(1'b1, 8'h80, 32'h0);
    apb(1'b1, 8'h84, 32'd50);
    put(5, 16'h0);
    apb(1'b1, 8'h00, 32'h51);
    put(5, 16'h1);
    repeat (150) @(posedge core_clk);
    chk("time end y", 32'd50, 32'(lut_out));
    chk("time range", 32'h00320000, {lut_out_max, lut_out_min});
    apb(1'b1, 8'h00, 32'h53);
    seen = 0;
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk);
      if (lut_out < 50) seen = 1;
    end
    chk("repeat", 32'h1, 32'(seen));
    $display("time mode done");
    close_out();
  end
endmodule
`default_nettype wire
